// ===== hw/irs_pkg.sv
package irs_pkg;

	localparam logic [2:0] MODE_STANDBY = 3'h0;
	localparam logic [2:0] MODE_NVM = 3'h1;
	localparam logic [2:0] MODE_SINGLE = 3'h2;
	localparam logic [2:0] MODE_CONT0 = 3'h4;
	localparam logic [2:0] MODE_CONT1 = 3'h5;
	localparam logic [2:0] MODE_CONT2 = 3'h6;
	localparam logic [2:0] MODE_CONT3 = 3'h7;

	localparam logic [6:0] ADDR_BASE = 7'h64;
	localparam logic [1:0] STRAP_SWITCH = 2'h3;

	localparam int CNT_W = 12;
	// Measurement length in core clocks; continuous 1..3 use the long one
	localparam logic [CNT_W-1:0] MEAS_BASE_CYC = 12'h010;
	localparam logic [CNT_W-1:0] MEAS_LONG_CYC = 12'h040;
	// Wait lengths give measure:wait of 1:1, 1:3, 1:7
	localparam logic [CNT_W-1:0] WAIT_C1_CYC = 12'h040;
	localparam logic [CNT_W-1:0] WAIT_C2_CYC = 12'h0c0;
	localparam logic [CNT_W-1:0] WAIT_C3_CYC = 12'h1c0;
	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_MEAS = 3'b001,
		PH_WAIT = 3'b010,
		PH_HOLD = 3'b011
	} irs_phase_t;

	typedef struct packed {
		logic signed [15:0] ch1;
		logic signed [15:0] ch2;
		logic signed [15:0] ch3;
		logic signed [15:0] ch4;
	} irs_ir_t;

	typedef struct packed {
		logic signed [15:0] thr_hi;
		logic signed [15:0] thr_lo;
		logic [15:0] hyst;
	} irs_thr_t;

	typedef struct packed {
		logic pdn_s1;
		logic pdn_s2;
		logic sup_s1;
		logic sup_s2;
		logic [1:0] strap_s1;
		logic [1:0] strap_s2;
		logic rd_s1;
		logic rd_s2;
		logic rd_s3;
		logic por_done;
		logic strap_ok;
		logic [1:0] strap;
		logic [6:0] bus_addr;
		logic switch_mode;
		logic bus_enable;
		logic [2:0] mode;
		irs_phase_t phase;
		logic [CNT_W-1:0] cnt;
		logic measuring;
		logic data_store;
		logic int_out;
		logic nvm_access;
		logic powered_down;
		logic soft_rst;
	} irs_core_t;

	typedef struct packed {
		logic bus_en_s1;
		logic bus_en_s2;
		logic rd_tgl;
	} irs_link_t;

endpackage

// ===== hw/irs_mode_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// (R1) Power-on reset restores registers, enters stand-by
// (R2) No power-on reset while power-down pin low
// (R3) Power-down pin low resets, halts everything
// (R4) Soft reset bit resets like other sources
// (R5) Digital supply low resets the device
// (R6) Every reset restores all initial values; here por_done and powered_down follow the pin on all but the i_resetn reset
// (R7) Straps pick address 64h, 65h or 66h
// (R8) Both straps high: switch mode, bus off
// (R9) Host keeps bus idle in switch mode
// (R10) Switch mode: window breach drives interrupt
// (R11) Hysteresis from memory stops interrupt chatter
// (R12) Mode field encodings select operating modes
// (R13) Single shot measures once, stand-by after read
// (R14) Continuous 0 measures back to back
// (R15) Continuous 1: 1:1 ratio, eight times period
// (R16) Continuous 2: 1:3 ratio, twice continuous 1
// (R17) Continuous 3: 1:7 ratio, twice continuous 2
// (R18) Host waits memory write time before commands
// (R19) Host changes modes only through stand-by
// (R20) Memory access only in mode 001 enabled
// (R21) Switch mode repeats measurements automatically
// (R22) Soft reset bit clears itself after reset
module irs_mode_ctrl
	import irs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_link_clk,
	input wire logic i_power_down_pin_n,
	input wire logic i_digital_supply_low,
	input wire logic i_addr_strap_0,
	input wire logic i_addr_strap_1,
	input wire logic i_soft_reset_bit,
	input wire logic i_mode_write,
	input wire logic [2:0] i_op_mode_field,
	input wire logic i_nvm_access_enable,
	input wire logic i_link_read_done,
	input wire irs_ir_t i_ir,
	input wire irs_thr_t i_nvm_thr,
	output logic o_int,
	output logic [6:0] o_bus_addr,
	output logic o_bus_enable,
	output logic o_switch_mode,
	output logic [2:0] o_op_mode_field,
	output logic o_measuring,
	output logic o_data_store,
	output logic o_nvm_access,
	output logic o_powered_down,
	output logic o_soft_reset_bit
);

	irs_core_t s;
	irs_core_t n;
	irs_link_t l;
	irs_link_t ln;
	logic rst_req;
	logic rd_evt;
	logic quiet;
	logic signed [16:0] d13;
	logic signed [16:0] d24;

	function automatic logic [CNT_W-1:0] meas_len(input logic [2:0] m);
		logic [CNT_W-1:0] r;
		r = MEAS_LONG_CYC;
		if (m == MODE_CONT0 || m == MODE_SINGLE) begin
			r = MEAS_BASE_CYC;
		end
		return r;
	endfunction

	function automatic logic [CNT_W-1:0] wait_len(input logic [2:0] m);
		logic [CNT_W-1:0] r;
		case (m)
			MODE_CONT1: r = WAIT_C1_CYC;
			MODE_CONT2: r = WAIT_C2_CYC;
			MODE_CONT3: r = WAIT_C3_CYC;
			default: r = '0;
		endcase
		return r;
	endfunction

	// Once active, the output only releases when the difference is back inside
	// the window narrowed by the hysteresis on both sides
	function automatic logic beyond(input logic signed [16:0] d, input irs_thr_t t, input logic act);
		logic signed [17:0] hx;
		logic signed [17:0] lx;
		logic signed [17:0] hy;
		logic signed [17:0] dx;
		hx = {{2{t.thr_hi[15]}}, t.thr_hi};
		lx = {{2{t.thr_lo[15]}}, t.thr_lo};
		hy = {2'b00, t.hyst};
		dx = {d[16], d};
		if (act) begin
			hx = hx - hy;
			lx = lx + hy;
		end
		return (dx > hx) || (dx < lx);
	endfunction

	assign d13 = 17'({i_ir.ch1[15], i_ir.ch1} - {i_ir.ch3[15], i_ir.ch3});
	assign d24 = 17'({i_ir.ch2[15], i_ir.ch2} - {i_ir.ch4[15], i_ir.ch4});

	assign rd_evt = s.rd_s2 ^ s.rd_s3;
	assign rst_req = !s.pdn_s2 || s.sup_s2 || s.soft_rst || !s.por_done; // see (R3) (R4) (R5)
	assign quiet = !rst_req && !i_mode_write;

	always_comb begin
		n = s;
		n.pdn_s1 = i_power_down_pin_n;
		n.pdn_s2 = s.pdn_s1;
		n.sup_s1 = i_digital_supply_low;
		n.sup_s2 = s.sup_s1;
		n.strap_s1 = {i_addr_strap_1, i_addr_strap_0};
		n.strap_s2 = s.strap_s1;
		n.rd_s1 = l.rd_tgl;
		n.rd_s2 = s.rd_s1;
		n.rd_s3 = s.rd_s2;
		n.data_store = 1'b0;
		if (rst_req) begin
			// All state back to initial values except por_done and powered_down, which follow the pin; the synchronisers keep running
			n.por_done = s.pdn_s2; // see (R2)
			n.strap_ok = 1'b0; // see (R6)
			n.strap = '0;
			n.bus_addr = '0;
			n.switch_mode = 1'b0;
			n.bus_enable = 1'b0;
			n.mode = MODE_STANDBY; // see (R1)
			n.phase = PH_IDLE;
			n.cnt = '0;
			n.int_out = 1'b0;
			n.nvm_access = 1'b0;
			n.powered_down = !s.pdn_s2; // see (R3)
			n.soft_rst = 1'b0; // see (R22)
		end else if (!s.strap_ok) begin
			n.strap_ok = 1'b1;
			n.strap = s.strap_s2;
			n.bus_addr = ADDR_BASE + {5'h00, s.strap_s2}; // see (R7)
			n.switch_mode = (s.strap_s2 == STRAP_SWITCH); // see (R8)
			n.bus_enable = (s.strap_s2 != STRAP_SWITCH);
			if (s.strap_s2 == STRAP_SWITCH) begin
				// Stand-alone use has no host to start it
				n.mode = MODE_CONT0; // see (R21)
				n.phase = PH_MEAS;
				n.cnt = '0;
			end
		end else if (i_mode_write && !s.switch_mode) begin
			// A rewrite aborts any running measurement; old data stays valid
			n.mode = i_op_mode_field; // see (R12)
			n.cnt = '0;
			n.nvm_access = (i_op_mode_field == MODE_NVM) && i_nvm_access_enable; // see (R20)
			n.phase = i_op_mode_field[2] || i_op_mode_field == MODE_SINGLE ? PH_MEAS : PH_IDLE;
		end else begin
			case (s.phase)
				PH_IDLE: begin
					n.cnt = '0;
				end
				PH_MEAS: begin
					n.cnt = s.cnt + CNT_ONE;
					if (s.cnt == meas_len(s.mode) - CNT_ONE) begin
						n.data_store = 1'b1;
						n.cnt = '0;
						if (s.switch_mode) begin
							n.int_out = beyond(d13, i_nvm_thr, s.int_out) || beyond(d24, i_nvm_thr, s.int_out); // see (R10) (R11)
						end
						if (s.mode == MODE_SINGLE) begin
							n.phase = PH_HOLD; // see (R13)
						end else if (wait_len(s.mode) == '0) begin
							n.phase = PH_MEAS; // see (R14)
						end else begin
							n.phase = PH_WAIT; // see (R15) (R16) (R17)
						end
					end
				end
				PH_WAIT: begin
					n.cnt = s.cnt + CNT_ONE;
					if (s.cnt == wait_len(s.mode) - CNT_ONE) begin
						n.cnt = '0;
						n.phase = PH_MEAS;
					end
				end
				PH_HOLD: begin
					if (rd_evt) begin
						n.mode = MODE_STANDBY; // see (R13)
						n.phase = PH_IDLE;
					end
				end
				default: begin
					n.phase = PH_IDLE;
				end
			endcase
		end
		// A write landing in a reset cycle is kept, so it is lost only while the power-down pin is low
		if (i_soft_reset_bit && s.pdn_s2) begin
			n.soft_rst = 1'b1; // see (R4)
		end
		n.measuring = (n.phase == PH_MEAS);
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s <= '0;
			s.powered_down <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Link side: the host's end-of-read arrives on the bus clock and crosses as a toggle
	always_comb begin
		ln = l;
		ln.bus_en_s1 = s.bus_enable;
		ln.bus_en_s2 = l.bus_en_s1;
		if (i_link_read_done && l.bus_en_s2) begin
			ln.rd_tgl = !l.rd_tgl; // see (R9)
		end
	end

	always_ff @(posedge i_link_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			l <= '0;
		end else begin
			l <= ln;
		end
	end

	assign o_int = s.int_out;
	assign o_bus_addr = s.bus_addr;
	assign o_bus_enable = s.bus_enable;
	assign o_switch_mode = s.switch_mode;
	assign o_op_mode_field = s.mode;
	assign o_measuring = s.measuring;
	assign o_data_store = s.data_store;
	assign o_nvm_access = s.nvm_access;
	assign o_powered_down = s.powered_down;
	assign o_soft_reset_bit = s.soft_rst;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	sequence seq_meas_done;
		s.data_store && quiet;
	endsequence

	sequence seq_read_in_hold;
		s.phase == PH_HOLD && rd_evt && quiet;
	endsequence

	a_pdn_halts: assert property (!s.pdn_s2 |=> o_powered_down && !o_measuring && o_op_mode_field == MODE_STANDBY) // see (R3)
		else $error("power-down pin low did not halt the block");

	a_supply_reset: assert property (s.sup_s2 |=> s.phase == PH_IDLE && !s.strap_ok && !o_int) // see (R5)
		else $error("supply low did not reset the block");

	a_soft_self_clear: assert property (o_soft_reset_bit && !i_soft_reset_bit |=> !o_soft_reset_bit && o_op_mode_field == MODE_STANDBY) // see (R22)
		else $error("soft reset bit did not clear or reset");

	a_addr_strap: assert property (s.strap_ok && !o_switch_mode |-> o_bus_addr == ADDR_BASE + {5'h00, s.strap} && o_bus_enable) // see (R7)
		else $error("bus address does not follow straps");

	a_switch_bus_off: assert property (s.strap_ok && s.strap == STRAP_SWITCH |-> o_switch_mode && !o_bus_enable) // see (R8)
		else $error("switch mode left bus enabled");

	a_single_return: assert property (seq_read_in_hold |=> o_op_mode_field == MODE_STANDBY && !o_measuring) // see (R13)
		else $error("single shot did not return to stand-by");

	a_cont0_repeat: assert property (seq_meas_done ##0 s.mode == MODE_CONT0 |-> s.phase == PH_MEAS ##1 o_measuring[*2]) // see (R14)
		else $error("continuous 0 did not restart at once");

	a_meas_length: assert property (seq_meas_done |-> $past(s.cnt) == meas_len(s.mode) - CNT_ONE) // see (R15)
		else $error("measurement length wrong");

	a_wait_length: assert property ($past(s.phase) == PH_WAIT && s.phase == PH_MEAS && $past(quiet)
		|-> $past(s.cnt) == wait_len(s.mode) - CNT_ONE) // see (R16) (R17)
		else $error("wait length wrong for mode");

	a_nvm_gate: assert property (o_nvm_access |-> o_op_mode_field == MODE_NVM && !o_measuring) // see (R20)
		else $error("memory access outside its mode");

	a_int_switch_only: assert property (!o_switch_mode |-> !o_int) // see (R10)
		else $error("interrupt active outside switch mode");

	a_int_on_store: assert property ($changed(o_int) && !$past(rst_req) |-> o_data_store) // see (R11)
		else $error("interrupt changed without a new result");

	a_switch_auto: assert property (o_switch_mode |-> o_measuring && o_op_mode_field == MODE_CONT0) // see (R21)
		else $error("switch mode not measuring continuously");

	// Pin low keeps the power-on release from completing until the pin rises
	a_por_held: assert property (!s.pdn_s2 |=> !s.por_done && !s.strap_ok) // see (R2)
		else $error("power-on release went ahead with pin low");

	sequence seq_soft_applied;
		o_soft_reset_bit ##1 o_op_mode_field == MODE_STANDBY && !o_measuring;
	endsequence

	a_soft_take: assert property (i_soft_reset_bit && s.pdn_s2 |=> seq_soft_applied) // see (R4)
		else $error("soft reset request not applied");

	sequence seq_write_taken;
		i_mode_write && s.strap_ok && !s.switch_mode && !rst_req;
	endsequence

	a_mode_write: assert property (seq_write_taken |=> o_op_mode_field == $past(i_op_mode_field)) // see (R12)
		else $error("mode write not taken");

	a_single_once: assert property (seq_meas_done ##0 s.mode == MODE_SINGLE |=> !o_measuring) // see (R13)
		else $error("single shot measured again");

endmodule

// ===== verif/irs_host_model.sv
`timescale 1ns/10ps
module irs_host_model (
	output logic o_link_clk,
	output logic o_read_done
);
	initial begin
		o_link_clk = 1'b0;
		o_read_done = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) begin
			#3 o_link_clk = 1'b1;
			#3 o_link_clk = 1'b0;
		end
	endtask
	// Clock stands still between frames; never used in switch mode
	task automatic send_read_done();
		#1.3;
		tick(3);
		o_read_done = 1'b1;
		tick(1);
		o_read_done = 1'b0;
		tick(3);
	endtask
endmodule

// ===== verif/ir_sensor_mode_reset_control_tb.sv
`timescale 1ns/10ps
module ir_sensor_mode_reset_control_tb;
	import irs_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, power_down_pin_n = 1'b1, sup = 1'b0, soft_reset_bit = 1'b0, wr = 1'b0, nvm_en = 1'b0;
	logic [1:0] strap = 2'h0;
	logic [2:0] op = 3'h0;
	irs_ir_t ir = '0;
	irs_thr_t thr = '{16'sh0064, -16'sh0064, 16'h000a};
	logic o_int, en, sw, meas, store, nvm, pd, srb, link_clk, rd;
	logic [6:0] addr;
	logic [2:0] mode;
	int n_mismatch = 0, check_count = 0, cyc = 0, m = 0;
	int p[4];
	always #2.5 clk = ~clk;
	irs_mode_ctrl irs_mode_ctrl_i (.i_clk(clk), .i_resetn(resetn), .i_link_clk(link_clk),
		.i_power_down_pin_n(power_down_pin_n), .i_digital_supply_low(sup), .i_addr_strap_0(strap[0]),
		.i_addr_strap_1(strap[1]), .i_soft_reset_bit(soft_reset_bit), .i_mode_write(wr), .i_op_mode_field(op),
		.i_nvm_access_enable(nvm_en), .i_link_read_done(rd), .i_ir(ir), .i_nvm_thr(thr), .o_int(o_int),
		.o_bus_addr(addr), .o_bus_enable(en), .o_switch_mode(sw), .o_op_mode_field(mode),
		.o_measuring(meas), .o_data_store(store), .o_nvm_access(nvm), .o_powered_down(pd),
		.o_soft_reset_bit(srb));
	irs_host_model irs_host_model_i (.o_link_clk(link_clk), .o_read_done(rd));
	task automatic print_verdict();
		$display("mismatches %0d, checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic do_reset(input logic [1:0] s);
		resetn = 1'b0;
		strap = s;
		cyc_n(12);
		resetn = 1'b1;
		cyc_n(10);
	endtask
	task automatic set_mode(input logic [2:0] md, input logic e);
		op = md;
		nvm_en = e;
		wr = 1'b1;
		cyc_n(1);
		wr = 1'b0;
		cyc_n(1);
	endtask
	task automatic wait_store();
		cyc_n(1);
		for (int k = 0; k < 1000 && store !== 1'b1; k++)
			cyc_n(1);
		chk(store, 1'b1);
	endtask
	// Period and measuring cycles between two stores
	task automatic run_mode(input logic [2:0] md, output int per, output int ml);
		set_mode(MODE_STANDBY, 1'b0);
		set_mode(md, 1'b0);
		wait_store();
		per = 0;
		ml = 0;
		do begin
			cyc_n(1);
			per++;
			ml += meas;
		end while (store !== 1'b1 && per < 1000);
	endtask
	task automatic t_straps();
		for (int s = 0; s < 3; s++) begin
			do_reset(s[1:0]);
			chk(addr, ADDR_BASE + 7'(s));
			chk({en, sw, mode, pd, srb, nvm, meas, o_int}, 10'h200);
		end
	endtask
	task automatic t_modes();
		run_mode(MODE_CONT0, p[0], m);
		chk(mode, MODE_CONT0);
		for (int i = 1; i < 4; i++) begin
			run_mode(MODE_CONT0 + 3'(i), p[i], m);
			chk(16'(p[i] - m), 16'(m * ((1 << i) - 1)));
			chk(16'(p[i]), 16'(p[i-1] * (i == 1 ? 8 : 2)));
		end
		set_mode(MODE_STANDBY, 1'b0);
		cyc_n(3);
		chk({meas, mode}, 4'h0);
	endtask
	task automatic t_single();
		set_mode(MODE_SINGLE, 1'b0);
		wait_store();
		cyc_n(20);
		chk({meas, mode}, {1'b0, MODE_SINGLE});
		irs_host_model_i.send_read_done();
		cyc_n(6);
		chk(mode, MODE_STANDBY);
	endtask
	task automatic t_resets();
		set_mode(MODE_CONT0, 1'b0);
		cyc_n(5);
		soft_reset_bit = 1'b1;
		cyc_n(1);
		chk(srb, 1'b1);
		soft_reset_bit = 1'b0;
		cyc_n(4);
		chk({srb, meas, mode}, 5'h00);
		set_mode(MODE_CONT0, 1'b0);
		power_down_pin_n = 1'b0;
		cyc_n(6);
		chk({pd, meas, mode}, 5'h10);
		power_down_pin_n = 1'b1;
		cyc_n(10);
		chk({pd, en, addr}, {2'h1, ADDR_BASE + 7'h2});
		set_mode(MODE_CONT0, 1'b0);
		sup = 1'b1;
		cyc_n(6);
		chk({meas, mode}, 4'h0);
		sup = 1'b0;
		cyc_n(10);
		// Memory mode is only entered, never written, so no write time is owed
		set_mode(MODE_NVM, 1'b1);
		chk(nvm, 1'b1);
		set_mode(MODE_STANDBY, 1'b0);
		set_mode(MODE_NVM, 1'b0);
		chk(nvm, 1'b0);
	endtask
	// Reset released with the pin low must wait for the pin before coming up
	task automatic t_por_held();
		power_down_pin_n = 1'b0;
		do_reset(2'h1);
		chk({pd, en, addr}, 9'h100);
		power_down_pin_n = 1'b1;
		cyc_n(10);
		chk({pd, en, addr}, {2'h1, ADDR_BASE + 7'h1});
	endtask
	task automatic ir_step(input logic signed [15:0] d1, input logic signed [15:0] d2, input logic e);
		ir = '{d1, d2, 16'sh0000, 16'sh0000};
		wait_store();
		wait_store();
		cyc_n(2);
		chk(o_int, e);
	endtask
	task automatic t_switch();
		do_reset(STRAP_SWITCH);
		chk({en, sw}, 2'h1);
		set_mode(MODE_STANDBY, 1'b0);
		wait_store();
		ir_step(16'sh00c8, 16'sh0000, 1'b1);
		ir_step(16'sh005f, 16'sh0000, 1'b1);
		ir_step(16'sh0032, 16'sh0000, 1'b0);
		ir_step(16'sh0000, -16'sh00c8, 1'b1);
	endtask
	initial begin
		t_straps();
		t_modes();
		t_single();
		t_resets();
		t_por_held();
		t_switch();
		print_verdict();
	end
endmodule
